// >>> hdl/pwr_ctl_regs.svh
// Timing constants for the converter pair power control
`ifndef PWR_CTL_REGS_SVH
`define PWR_CTL_REGS_SVH
`define CLK_PERIOD_NS 10
`define CONV_TIME_NS 3000
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PPD_RECOVERY_NS 1000
`define STANDBY_N_WAKE_NS 2000
`define PAIR_COUNT 3
`endif

// >>> hdl/pwr_ctl_pkg.sv
// Types shared by the converter pair power control
`default_nettype none
package pwr_ctl_pkg;
	typedef enum logic [1:0] {
		PAIR_ON = 2'b00,
		PAIR_DOWN = 2'b01,
		PAIR_WAKE = 2'b11
	} pair_state_e;
	typedef enum logic [1:0] {
		DEV_IDLE = 2'b00,
		DEV_CONV = 2'b01,
		DEV_STANDBY_N = 2'b11,
		DEV_WAKE = 2'b10
	} dev_state_e;
endpackage
`default_nettype wire

// >>> hdl/pair_power.sv
// Power state of one converter pair
`default_nettype none
`include "pwr_ctl_regs.svh"
module pair_power
	import pwr_ctl_pkg::*;
#(
	parameter int RECOVERY_CYCLES = 100
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic start_level,
	input wire logic conv_end,
	input wire logic triggered,
	output logic powered,
	output logic tracking
);
	initial begin
		if (RECOVERY_CYCLES < 1) begin
			$error("RECOVERY_CYCLES must be at least 1");
		end
	end
	localparam int CW = $clog2(RECOVERY_CYCLES + 1);
	pair_state_e state_r, state_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		unique case (state_r)
			PAIR_ON: begin
				if (conv_end && triggered && !start_level) begin
					state_nxt = PAIR_DOWN;
				end
			end
			PAIR_DOWN: begin
				if (start_level) begin
					state_nxt = PAIR_WAKE;
					cnt_nxt = CW'(RECOVERY_CYCLES);
				end
			end
			PAIR_WAKE: begin
				if (cnt_r <= CW'(1)) begin
					state_nxt = PAIR_ON;
					cnt_nxt = '0;
				end else begin
					cnt_nxt = cnt_r - CW'(1);
				end
			end
			default: begin
				state_nxt = PAIR_ON;
				cnt_nxt = '0;
			end
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_r <= PAIR_ON;
			cnt_r <= '0;
		end else if (clk_en) begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	assign powered = (state_r == PAIR_ON);
	// Track mode starts as soon as the wake request arrives
	assign tracking = (state_r != PAIR_DOWN);
endmodule // pair_power
`default_nettype wire

// >>> hdl/adc_pair_power_down_control.sv
// Conversion start, busy and power modes of a three pair converter
//Contract
//- Rising start edge begins simultaneous conversion on that pair.
//- Busy rises at start, falls 3 us later.
//- Start edges ignored while busy is high.
//- Start held low before busy falls powers the pair down.
//- Power-down only for pairs that triggered the finished conversion.
//- Start high wakes the pair and puts it into track mode.
//- Reference buffers stay powered during partial power-down.
//- Other powered pairs convert normally meanwhile.
//- Standby low puts whole device into low-power state.
//- Standby high returns the device to normal operation.
//- Output data buffers keep working in standby.
`default_nettype none
`include "pwr_ctl_regs.svh"
module adc_pair_power_down_control
	import pwr_ctl_pkg::*;
#(
	parameter int CONV_CYCLES = `CONV_CYCLES,
	parameter int RECOVERY_CYCLES = (`PPD_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int WAKE_CYCLES = (`STANDBY_N_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic pair1_conversion_start,
	input wire logic pair2_conversion_start,
	input wire logic pair3_conversion_start,
	input wire logic standby_n,
	output logic busy,
	output logic [`PAIR_COUNT-1:0] pair_sample,
	output logic [`PAIR_COUNT-1:0] pair_powered,
	output logic [`PAIR_COUNT-1:0] pair_tracking,
	output logic ref_buf_on,
	output logic core_powered,
	output logic data_buf_on
);
	initial begin
		if (CONV_CYCLES < 2 || WAKE_CYCLES < 1) begin
			$error("Conversion or wake-up count too small");
		end
	end
	localparam int CW = $clog2(CONV_CYCLES + WAKE_CYCLES + 1);
	logic [`PAIR_COUNT-1:0] start_pin, s1_r, s2_r, prev_r, rise, trig_r, trig_nxt;
	logic stby1_r, stby2_r, conv_end;
	dev_state_e dev_r, dev_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic [`PAIR_COUNT-1:0] sample_nxt, sample_r;
	assign start_pin = {pair3_conversion_start, pair2_conversion_start, pair1_conversion_start};
	// Pins are asynchronous to core_clk
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s1_r <= '0;
			s2_r <= '0;
			prev_r <= '0;
			stby1_r <= 1'b1;
			stby2_r <= 1'b1;
		end else if (clk_en) begin
			s1_r <= start_pin;
			s2_r <= s1_r;
			prev_r <= s2_r;
			stby1_r <= standby_n;
			stby2_r <= stby1_r;
		end
	end
	// Only fully powered pairs may take an edge
	assign rise = s2_r & ~prev_r & pair_powered;
	always_comb begin
		dev_nxt = dev_r;
		cnt_nxt = cnt_r;
		trig_nxt = trig_r;
		sample_nxt = '0;
		conv_end = 1'b0;
		unique case (dev_r)
			DEV_IDLE: begin
				if (!stby2_r) begin
					dev_nxt = DEV_STANDBY_N;
				end else if (|rise) begin
					dev_nxt = DEV_CONV;
					trig_nxt = rise;
					sample_nxt = rise;
					cnt_nxt = CW'(CONV_CYCLES - 1);
				end
			end
			DEV_CONV: begin
				// Edges here are dropped on purpose
				if (cnt_r == '0) begin
					dev_nxt = DEV_IDLE;
					conv_end = 1'b1;
				end else begin
					cnt_nxt = cnt_r - CW'(1);
				end
			end
			DEV_STANDBY_N: begin
				if (stby2_r) begin
					dev_nxt = DEV_WAKE;
					cnt_nxt = CW'(WAKE_CYCLES - 1);
				end
			end
			DEV_WAKE: begin
				if (!stby2_r) begin
					dev_nxt = DEV_STANDBY_N;
				end else if (cnt_r == '0) begin
					dev_nxt = DEV_IDLE;
				end else begin
					cnt_nxt = cnt_r - CW'(1);
				end
			end
			default: begin
				dev_nxt = DEV_IDLE;
				cnt_nxt = '0;
			end
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dev_r <= DEV_IDLE;
			cnt_r <= '0;
			trig_r <= '0;
			sample_r <= '0;
		end else if (clk_en) begin
			dev_r <= dev_nxt;
			cnt_r <= cnt_nxt;
			trig_r <= trig_nxt;
			sample_r <= sample_nxt;
		end
	end
	genvar gi;
	generate
		for (gi = 0; gi < `PAIR_COUNT; gi++) begin : g_pair
			pair_power #(
				.RECOVERY_CYCLES(RECOVERY_CYCLES)
			) u_pair (
				.core_clk(core_clk),
				.rst(rst),
				.clk_en(clk_en),
				.start_level(s2_r[gi]),
				.conv_end(conv_end),
				.triggered(trig_r[gi]),
				.powered(pair_powered[gi]),
				.tracking(pair_tracking[gi])
			);
		end
	endgenerate
	assign busy = (dev_r == DEV_CONV);
	assign pair_sample = sample_r;
	// Reference stays up unless the whole device sleeps
	assign ref_buf_on = (dev_r != DEV_STANDBY_N);
	assign core_powered = (dev_r == DEV_IDLE) || (dev_r == DEV_CONV);
	assign data_buf_on = 1'b1;
endmodule // adc_pair_power_down_control
`default_nettype wire

// >>> bench/adc_ppd_props.sv
// Port assertions for the converter pair power control
`default_nettype none
module adc_ppd_props (
	input wire logic core_clk, rst, busy, ref_buf_on, core_powered, data_buf_on,
	input wire logic [2:0] pair_sample, pair_powered, pair_tracking
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	start_samples_a: assert property ($rose(busy) |-> pair_sample != 3'h0)
		else $error("busy rose with no pair");
	conv_length_a: assert property ($rose(busy) |-> ##299 busy ##1 !busy)
		else $error("conversion length");
	sample_once_a: assert property (pair_sample != 3'h0 |-> $rose(busy))
		else $error("sample while busy");
	down_at_end_a: assert property ($fell(pair_powered[0]) |-> $past(busy) && !busy)
		else $error("power-down off busy fall");
	down_holds_a: assert property ($fell(pair_powered[0]) |-> !pair_tracking[0])
		else $error("down pair tracking");
	wake_pair_a: assert property ($rose(pair_tracking[0]) |-> ##[1:8] pair_powered[0])
		else $error("pair never powered");
	refs_kept_a: assert property (pair_powered != 3'h7 && core_powered |-> ref_buf_on)
		else $error("refs off in power-down");
	standby_quiet_a: assert property (!core_powered |-> !busy && pair_sample == 3'h0)
		else $error("conversion in standby");
	data_kept_a: assert property (!ref_buf_on |-> data_buf_on)
		else $error("data buffers off");
endmodule // adc_ppd_props
bind adc_pair_power_down_control adc_ppd_props i_adc_ppd_props (.core_clk, .rst, .busy,
	.ref_buf_on, .core_powered, .data_buf_on, .pair_sample, .pair_powered, .pair_tracking);
`default_nettype wire

// >>> bench/host_model.sv
// Host driving the start and standby pins
`default_nettype none
module host_model (
	input wire logic core_clk,
	output logic [2:0] start,
	output logic standby_n
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		start = 3'h0;
		standby_n = 1'b1;
	end
	// Pins move just after the edge, never on it
	task automatic pins(input logic [2:0] s, input logic sb);
		@(posedge core_clk);
		#1;
		start = s;
		standby_n = sb;
	endtask
endmodule // host_model
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the pair power control
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0, rst = 1'b1, busy, ref_buf_on, core_powered, data_buf_on, standby_n;
	logic clk_en = 1'b1;
	logic [2:0] start, pair_sample, pair_powered, pair_tracking;
	int mismatches = 0, samples_checked = 0, n;
	logic [5:0] rows [5] = '{6'h09, 6'h12, 6'h24, 6'h3f, 6'h2d};
	always #5 core_clk = ~core_clk;
	host_model i_host_model (.core_clk, .start, .standby_n);
	adc_pair_power_down_control #(.RECOVERY_CYCLES(4), .WAKE_CYCLES(4))
		i_adc_pair_power_down_control (.core_clk, .rst, .clk_en,
		.pair1_conversion_start(start[0]), .pair2_conversion_start(start[1]),
		.pair3_conversion_start(start[2]), .standby_n, .busy, .pair_sample, .pair_powered,
		.pair_tracking, .ref_buf_on, .core_powered, .data_buf_on);
	task automatic ck(input logic [8:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge core_clk);
		#2;
	endtask
	// One conversion; pins go to mid while busy
	task automatic conv(input logic [2:0] s, mid, exp);
		i_host_model.pins(s, 1'b1);
		n = 0;
		while (busy !== 1'b1 && n < 9) begin
			step(1);
			n++;
		end
		ck(pair_sample, exp);
		n = 0;
		while (busy === 1'b1 && n < 400) begin
			if (n == 9) i_host_model.pins(mid, 1'b1);
			step(1);
			n++;
		end
		// Pin change uses up one edge of the count
		ck(n[8:0], 9'd299);
	endtask
	task automatic end_of_test;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#200000;
		mismatches++;
		end_of_test;
	end
	initial begin
		step(10);
		rst = 1'b0;
		ck({busy, ref_buf_on, core_powered, data_buf_on}, 9'h7);
		ck({pair_powered, pair_tracking}, 9'h3f);
		$display("reset done");
		foreach (rows[i]) begin
			conv(rows[i][5:3], rows[i][5:3], rows[i][2:0]);
			i_host_model.pins(3'h0, 1'b1);
			step(3);
			ck(pair_powered, 3'h7);
			$display("row %0d done", i);
		end
		conv(3'h1, 3'h3, 3'h1);
		step(6);
		ck(busy, 1'b0);
		i_host_model.pins(3'h0, 1'b1);
		step(3);
		conv(3'h1, 3'h0, 3'h1);
		step(2);
		ck({pair_powered, pair_tracking}, 9'h36);
		ck(ref_buf_on, 1'b1);
		conv(3'h2, 3'h2, 3'h2);
		step(2);
		ck(pair_powered, 3'h6);
		i_host_model.pins(3'h3, 1'b1);
		step(20);
		ck({pair_powered, pair_tracking}, 9'h3f);
		i_host_model.pins(3'h0, 1'b1);
		step(3);
		conv(3'h1, 3'h1, 3'h1);
		$display("power-down done");
		i_host_model.pins(3'h0, 1'b0);
		step(6);
		ck({core_powered, ref_buf_on, data_buf_on}, 9'h1);
		i_host_model.pins(3'h1, 1'b0);
		step(6);
		ck({busy, pair_sample}, 9'h0);
		i_host_model.pins(3'h0, 1'b1);
		step(12);
		ck({core_powered, ref_buf_on}, 9'h3);
		conv(3'h4, 3'h4, 3'h4);
		$display("standby done");
		i_host_model.pins(3'h0, 1'b1);
		step(3);
		// Frozen enable must hold off a start edge until released
		clk_en = 1'b0;
		i_host_model.pins(3'h2, 1'b1);
		step(6);
		ck({busy, pair_sample}, 9'h0);
		clk_en = 1'b1;
		step(3);
		ck({busy, pair_sample}, 9'h0a);
		step(300);
		ck(busy, 1'b0);
		$display("enable done");
		end_of_test;
	end
endmodule // tb
`default_nettype wire
